//--- verilog/idmap_pkg.sv
// Purpose: shared constants and carriers for the id / rom map / post error block
// Assumes: apb with 32-bit data, registers one aligned word each
// Notes:   offsets are byte addresses
package idmap_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_UID_UPPER  = 8'h24;
  localparam logic [7:0] OFS_UID_LOWER  = 8'h28;
  localparam logic [7:0] OFS_ROM_MAP    = 8'h34;
  localparam logic [7:0] OFS_POST_LOW   = 8'h38;
  localparam logic [7:0] OFS_POST_HIGH  = 8'h3c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h64;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h68;
  localparam logic [7:0] OFS_ID_STATE   = 8'h6c;

  // reset values
  localparam logic [31:0] UID_RESET     = 32'h0000_0000;
  localparam logic [31:0] ROM_MAP_RESET = 32'h0000_0000;
  localparam logic [31:0] POST_RESET    = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;

  // field positions
  localparam int ROM_BASE_LSB = 10;
  localparam int ROM_OFS_BITS = 10;
  localparam int IRQ_BIT_POST = 0;
  localparam int IRQ_BIT_LOAD = 1;

  // config rom window in 1394 offset space, inclusive
  localparam logic [47:0] ROM_WIN_LO = 48'hffff_f000_0400;
  localparam logic [47:0] ROM_WIN_HI = 48'hffff_f000_07ff;

  // unmapped read answer
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  // quadlet read request from the 1394 side
  typedef struct packed {
    logic        valid;
    logic [47:0] offset;
  } rom_req_type;

  // translated host address
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] addr;
  } rom_rsp_type;

  // failing posted write report
  typedef struct packed {
    logic        valid;
    logic [15:0] requester;
    logic [47:0] offset;
  } post_err_type;

  // serial rom load result
  typedef struct packed {
    logic        valid;
    logic [31:0] upper;
    logic [31:0] lower;
  } id_load_type;

endpackage

//--- verilog/rom_map_xlate.sv
// Purpose: turns config rom quadlet read offsets into host addresses
// Assumes: base register value supplied by the register block
// Notes:   answer one cycle after the request, from a register
`timescale 1ns/1ns
module rom_map_xlate (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [31:0]          base,
  input  wire idmap_pkg::rom_req_type req,
  output      idmap_pkg::rom_rsp_type rsp
);

  typedef struct packed {
    idmap_pkg::rom_rsp_type rsp;
  } xl_state_type;

  xl_state_type s_q;
  xl_state_type s_d;
  logic         in_win;

  ////////////////////////////////////////////////////////////////////
  // window check and address sum
  always_comb begin
    in_win = (req.offset >= idmap_pkg::ROM_WIN_LO) &&
             (req.offset <= idmap_pkg::ROM_WIN_HI);
    s_d           = s_q;
    s_d.rsp.valid = req.valid;
    s_d.rsp.hit   = req.valid && in_win;
    if (req.valid && in_win) begin
      s_d.rsp.addr = base + {22'h0,
        req.offset[idmap_pkg::ROM_OFS_BITS-1:0]};
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;

endmodule

//--- verilog/idmap_regs.sv
// Purpose: unique id, config rom map and posted write error registers
// Assumes: apb slave, pready always high, no wait states
// Notes:   status bits are sticky; set wins over clear
//
// Overview of operation
// - upper id quadlet is read-only, holds maker code and upper serial
// - upper id clears to zero on reset, an invalid identifier
// - with serial rom present, id loads from serial rom after reset
// - once loaded the id is locked; software writes do nothing
// - without serial rom the id never changes from reset value
// - lower id quadlet read-only, reset zero, loaded and locked alike
// - map base bits 31..10 writable, bits 9..0 read zero
// - rom window read address is base plus low ten offset bits
// - failed posted write records error info in read-only registers
// - post low register captures lower 32 destination offset bits
// - post high holds requester node high, upper offset bits low
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module idmap_regs (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire idmap_pkg::apb_req_type  apb_req,
  output      idmap_pkg::apb_rsp_type  apb_rsp,
  input  wire logic                    rom_present,
  input  wire idmap_pkg::id_load_type  id_load,
  input  wire idmap_pkg::post_err_type post_err,
  input  wire idmap_pkg::rom_req_type  rom_req,
  output      idmap_pkg::rom_rsp_type  rom_rsp,
  output      logic                    irq
);

  typedef struct packed {
    logic [31:0] uid_upper;
    logic [31:0] uid_lower;
    logic        uid_locked;
    logic [21:0] map_base;
    logic [31:0] post_low;
    logic [31:0] post_high;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic        irq;
    idmap_pkg::apb_rsp_type rsp;
  } reg_state_type;

  reg_state_type s_q;
  reg_state_type s_d;
  logic          wr_en;
  logic          rd_en;
  logic [31:0]   base_word;
  logic [1:0]    ev;
  logic [1:0]    clr;

  ////////////////////////////////////////////////////////////////////
  // apb decode, single-cycle access phase
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign base_word = {s_q.map_base, 10'h000};

  // next state
  always_comb begin
    s_d = s_q;
    ev  = 2'h0;
    clr = 2'h0;
    // id load: only once, only with serial rom
    if (id_load.valid && rom_present && !s_q.uid_locked) begin
      s_d.uid_upper  = id_load.upper;
      s_d.uid_lower  = id_load.lower;
      s_d.uid_locked = 1'b1;
      ev[idmap_pkg::IRQ_BIT_LOAD] = 1'b1;
    end
    // capture failing posted write
    if (post_err.valid) begin
      s_d.post_low  = post_err.offset[31:0];
      s_d.post_high = {post_err.requester, post_err.offset[47:32]};
      ev[idmap_pkg::IRQ_BIT_POST] = 1'b1;
    end
    // software writes; id registers ignore them
    if (wr_en) begin
      case (apb_req.paddr)
        idmap_pkg::OFS_ROM_MAP: begin
          s_d.map_base = apb_req.pwdata[31:idmap_pkg::ROM_BASE_LSB];
        end
        idmap_pkg::OFS_IRQ_CLEAR: begin
          clr = apb_req.pwdata[1:0];
        end
        idmap_pkg::OFS_IRQ_ENABLE: begin
          s_d.irq_enable = apb_req.pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // sticky status, set wins over clear
    s_d.irq_status = (s_q.irq_status & ~clr) | ev;
    s_d.irq = |(s_d.irq_status & s_d.irq_enable);
    // read data registered in the setup cycle
    s_d.rsp.pready  = 1'b1;
    s_d.rsp.pslverr = 1'b0;
    if (rd_en) begin
      case (apb_req.paddr)
        idmap_pkg::OFS_UID_UPPER:  s_d.rsp.prdata = s_q.uid_upper;
        idmap_pkg::OFS_UID_LOWER:  s_d.rsp.prdata = s_q.uid_lower;
        idmap_pkg::OFS_ROM_MAP:    s_d.rsp.prdata = base_word;
        idmap_pkg::OFS_POST_LOW:   s_d.rsp.prdata = s_q.post_low;
        idmap_pkg::OFS_POST_HIGH:  s_d.rsp.prdata = s_q.post_high;
        idmap_pkg::OFS_IRQ_STATUS: s_d.rsp.prdata = {30'h0, s_q.irq_status};
        idmap_pkg::OFS_IRQ_ENABLE: s_d.rsp.prdata = {30'h0, s_q.irq_enable};
        idmap_pkg::OFS_ID_STATE:   s_d.rsp.prdata = {30'h0,
                                     rom_present, s_q.uid_locked};
        default: s_d.rsp.prdata = idmap_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q            <= '0;
      s_q.uid_upper  <= idmap_pkg::UID_RESET;
      s_q.uid_lower  <= idmap_pkg::UID_RESET;
      s_q.map_base   <= idmap_pkg::ROM_MAP_RESET[31:10];
      s_q.post_low   <= idmap_pkg::POST_RESET;
      s_q.post_high  <= idmap_pkg::POST_RESET;
      s_q.irq_status <= idmap_pkg::IRQ_RESET;
      s_q.irq_enable <= idmap_pkg::IRQ_RESET;
      s_q.rsp.pready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign irq     = s_q.irq;

  ////////////////////////////////////////////////////////////////////
  // address translator
  rom_map_xlate u_xlate (
    .clk    (clk),
    .resetn (resetn),
    .base   (base_word),
    .req    (rom_req),
    .rsp    (rom_rsp)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  a_uid_reset_zero: assert property (
    @(posedge clk)
    $rose(resetn) |-> s_q.uid_upper == 32'h0 && s_q.uid_lower == 32'h0)
    else $error("id not zero after reset");
  a_uid_lock_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    s_q.uid_locked |=> $stable(s_q.uid_upper) && $stable(s_q.uid_lower))
    else $error("locked id changed");
  a_uid_no_rom: assert property (
    @(posedge clk) disable iff (!resetn)
    !rom_present && !s_q.uid_locked |=>
      s_q.uid_upper == 32'h0 && s_q.uid_lower == 32'h0)
    else $error("id changed without serial rom");
  a_uid_load_take: assert property (
    @(posedge clk) disable iff (!resetn)
    id_load.valid && rom_present && !s_q.uid_locked |=>
      s_q.uid_upper == $past(id_load.upper) &&
      s_q.uid_lower == $past(id_load.lower))
    else $error("id load not taken");
  a_map_low_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_en && apb_req.paddr == idmap_pkg::OFS_ROM_MAP |=>
      base_word == {$past(apb_req.pwdata[31:10]), 10'h0})
    else $error("map base write wrong");
  // any offset inside the window, not one fixed value
  a_map_xlate: assert property (
    @(posedge clk) disable iff (!resetn)
    rom_req.valid && rom_req.offset >= idmap_pkg::ROM_WIN_LO &&
      rom_req.offset <= idmap_pkg::ROM_WIN_HI |=>
      rom_rsp.valid && rom_rsp.hit &&
      rom_rsp.addr == $past(base_word) + {22'h0, $past(rom_req.offset[9:0])})
    else $error("rom translate wrong");
  // outside the window: answered, no hit, address kept
  a_map_miss_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    rom_req.valid && !(rom_req.offset >= idmap_pkg::ROM_WIN_LO &&
      rom_req.offset <= idmap_pkg::ROM_WIN_HI) |=>
      rom_rsp.valid && !rom_rsp.hit && $stable(rom_rsp.addr))
    else $error("rom miss changed address");
  a_post_low_cap: assert property (
    @(posedge clk) disable iff (!resetn)
    post_err.valid |=> s_q.post_low == $past(post_err.offset[31:0]))
    else $error("post low not captured");
  a_post_high_cap: assert property (
    @(posedge clk) disable iff (!resetn)
    post_err.valid |=> s_q.post_high[31:16] == $past(post_err.requester)
      && s_q.post_high[15:0] == $past(post_err.offset[47:32]))
    else $error("post high wrong");
  a_post_flag_set: assert property (
    @(posedge clk) disable iff (!resetn)
    post_err.valid |=> s_q.irq_status[idmap_pkg::IRQ_BIT_POST])
    else $error("post error flag not set");
  // sticky until software clears it
  a_post_flag_sticky: assert property (
    @(posedge clk) disable iff (!resetn)
    s_q.irq_status[idmap_pkg::IRQ_BIT_POST] &&
      !(wr_en && apb_req.paddr == idmap_pkg::OFS_IRQ_CLEAR) |=>
      s_q.irq_status[idmap_pkg::IRQ_BIT_POST])
    else $error("post error flag lost");
  a_uid_read_only: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_en && apb_req.paddr == idmap_pkg::OFS_UID_UPPER && !id_load.valid
      |=> $stable(s_q.uid_upper))
    else $error("id written by software");
  c_id_load: cover property (@(posedge clk) disable iff (!resetn)
    $rose(s_q.uid_locked));
  c_post_err: cover property (@(posedge clk) disable iff (!resetn)
    post_err.valid ##1 irq);
  c_rom_hit: cover property (@(posedge clk) disable iff (!resetn)
    rom_rsp.hit);

endmodule

//--- sim/far_side_model.sv
// Purpose: far side model: serial rom loader and 1394 requesters
// Assumes: every request is a one-cycle pulse set after a rising edge
// Notes:   idle fields show the inverse of the last value
`timescale 1ns/1ns
module far_side_model (
  input  wire logic              clk,
  output idmap_pkg::id_load_type  id_load,
  output idmap_pkg::post_err_type post_err,
  output idmap_pkg::rom_req_type  rom_req
);
  ////////////////////////////////////////////////////////////////////////////
  // idle at time zero
  initial begin
    id_load = '0;
    post_err = '0;
    rom_req = '0;
  end
  // one id load pulse
  task automatic load(input logic [63:0] v);
    id_load <= {1'b1, v};
    @(posedge clk);
    id_load <= {1'b0, ~v};
  endtask
  // one failed posted write report
  task automatic post(input logic [15:0] n, input logic [47:0] o);
    post_err <= {1'b1, n, o};
    @(posedge clk);
    post_err <= {1'b0, ~n, ~o};
  endtask
  // one quadlet read request
  task automatic read(input logic [47:0] o);
    rom_req <= {1'b1, o};
    @(posedge clk);
    rom_req <= {1'b0, ~o};
  endtask
endmodule

//--- sim/idmap_regs_tb.sv
// Purpose: self-checking bench for idmap_regs
// Assumes: apb slave answers when it raises pready
// Notes:   random values from a fixed seed
`timescale 1ns/1ns
module idmap_regs_tb;
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    rom_present = 1'b0;
  logic                    irq;
  idmap_pkg::apb_req_type  req = '0;
  idmap_pkg::apb_rsp_type  rsp;
  idmap_pkg::id_load_type  id_load;
  idmap_pkg::post_err_type post_err;
  idmap_pkg::rom_req_type  rom_req;
  idmap_pkg::rom_rsp_type  rom_rsp;
  int                      errors = 0;
  int                      checked = 0;
  integer                  seed = 32'h56d1;
  logic [63:0]             id;
  logic [31:0]             base, last, r;
  logic [47:0]             o;
  logic                    inwin;
  ////////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  always #5 clk = ~clk;
  idmap_regs idmap_regs_inst (.clk(clk), .resetn(resetn), .apb_req(req),
    .apb_rsp(rsp), .rom_present(rom_present), .id_load(id_load),
    .post_err(post_err), .rom_req(rom_req), .rom_rsp(rom_rsp), .irq(irq));
  far_side_model far_side_model_inst (.clk(clk), .id_load(id_load),
    .post_err(post_err), .rom_req(rom_req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
      errors++;
      final_report();
    end else begin
      q = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // read one register, compare data and error flag
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, '0, q);
    check(q, e);
    check({31'h0, rsp.pslverr}, 32'h0);
  endtask
  function automatic logic [31:0] xl(logic [31:0] b, logic [47:0] x);
    return (b & 32'hffff_fc00) + {22'h0, x[9:0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // reset values
    rdc(8'h24, 32'h0);
    rdc(8'h28, 32'h0);
    rdc(8'h34, 32'h0);
    // no serial rom: writes and loads do nothing
    apb(1'b1, 8'h24, 32'hffff_ffff, r);
    far_side_model_inst.load({$random(seed), $random(seed)});
    rdc(8'h24, 32'h0);
    rdc(8'h28, 32'h0);
    rdc(8'h6c, 32'h0);
    // serial rom present: one load, then locked
    rom_present <= 1'b1;
    id = {$random(seed), $random(seed)};
    far_side_model_inst.load(id);
    rdc(8'h24, id[63:32]);
    rdc(8'h28, id[31:0]);
    rdc(8'h6c, 32'h3);
    apb(1'b1, 8'h28, ~id[31:0], r);
    far_side_model_inst.load(~id);
    rdc(8'h24, id[63:32]);
    rdc(8'h28, id[31:0]);
    // rom map base and window translation
    last = '0;
    repeat (4) begin
      base = $random(seed);
      apb(1'b1, 8'h34, base, r);
      rdc(8'h34, base & 32'hffff_fc00);
      for (int k = 0; k < 6; k++) begin
        r = $random(seed);
        case (k)
          0: o = 48'hffff_f000_0400;
          1: o = 48'hffff_f000_07ff;
          2: o = 48'hffff_f000_03ff;
          3: o = 48'hffff_f000_0800;
          4: o = 48'hffff_f000_0400 | {38'h0, r[9:0]};
          default: o = {r[15:0], r};
        endcase
        inwin = o >= idmap_pkg::ROM_WIN_LO && o <= idmap_pkg::ROM_WIN_HI;
        if (inwin) last = xl(base, o);
        far_side_model_inst.read(o);
        #1;
        check({30'h0, rom_rsp.valid, rom_rsp.hit}, {31'h1, inwin});
        check(rom_rsp.addr, last);
        @(posedge clk);
      end
    end
    // failed posted writes with interrupt enabled, then cleared
    apb(1'b1, 8'h68, 32'h1, r);
    rdc(8'h68, 32'h1);
    repeat (3) begin
      r = $random(seed);
      o = {r[7:0], r[31:24], $random(seed)};
      far_side_model_inst.post(r[31:16], o);
      #1;
      check({31'h0, irq}, 32'h1);
      @(posedge clk);
      rdc(8'h38, o[31:0]);
      rdc(8'h3c, {r[31:16], o[47:32]});
      rdc(8'h60, 32'h3);
      apb(1'b1, 8'h64, 32'h1, r);
      rdc(8'h60, 32'h2);
      check({31'h0, irq}, 32'h0);
    end
    // masked: status set, interrupt stays low
    apb(1'b1, 8'h68, 32'h0, r);
    far_side_model_inst.post(16'h0, 48'h0);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdc(8'h60, 32'h3);
    // unmapped offset reads zero
    apb(1'b1, 8'h70, 32'hffff_ffff, r);
    rdc(8'h70, 32'h0);
    // mid-run reset clears id, lock, base and flags; load opens again
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdc(8'h24, 32'h0);
    rdc(8'h28, 32'h0);
    rdc(8'h34, 32'h0);
    rdc(8'h60, 32'h0);
    rdc(8'h6c, 32'h2);
    id = {$random(seed), $random(seed)};
    far_side_model_inst.load(id);
    rdc(8'h24, id[63:32]);
    rdc(8'h28, id[31:0]);
    final_report();
  end
endmodule
